//--- logic/occr_pkg.sv
// constants for the oscillator control register set
package occr_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OCCR_OFF_CONTROL = 8'h00;
	localparam logic [7:0] OCCR_OFF_DIVISOR = 8'h04;
	localparam logic [7:0] OCCR_OFF_FEEDBACK = 8'h08;
	localparam logic [7:0] OCCR_OFF_TUNING = 8'h0C;
	// control register field positions
	localparam int OCCR_CUR_SRC_LSB = 12;
	localparam int OCCR_NEW_SRC_LSB = 8;
	localparam int OCCR_FREEZE_BIT = 7;
	localparam int OCCR_PIN_FREEZE_BIT = 6;
	localparam int OCCR_LOCK_BIT = 5;
	localparam int OCCR_FAIL_BIT = 3;
	localparam int OCCR_SEC_EN_BIT = 1;
	localparam int OCCR_SWITCH_BIT = 0;
	// divisor register field positions
	localparam int OCCR_ROI_BIT = 15;
	localparam int OCCR_REDUCTION_LSB = 12;
	localparam int OCCR_RED_EN_BIT = 11;
	localparam int OCCR_FRC_POST_LSB = 8;
	localparam int OCCR_PLL_POST_LSB = 6;
	localparam int OCCR_PLL_PRE_LSB = 0;
	// feedback and tuning fields
	localparam int OCCR_MULT_LSB = 0;
	localparam int OCCR_TUNE_LSB = 0;
	// reset values
	localparam logic [2:0] OCCR_SRC_RST = 3'h7;
	localparam logic [2:0] OCCR_REDUCTION_RST = 3'h3;
	localparam logic [2:0] OCCR_FRC_POST_RST = 3'h0;
	localparam logic [1:0] OCCR_PLL_POST_RST = 2'h1;
	localparam logic [4:0] OCCR_PLL_PRE_RST = 5'h00;
	localparam logic [8:0] OCCR_MULT_RST = 9'h030;
	localparam logic [5:0] OCCR_TUNE_RST = 6'h00;
	// switching mode setting codes
	localparam logic [1:0] OCCR_MODE_ALL_ON = 2'h0;
	localparam logic [1:0] OCCR_MODE_NO_MONITOR = 2'h1;
endpackage : occr_pkg

//--- logic/occr_regs.sv
// oscillator control and status registers behind a classic wishbone slave
// Functional notes
// - current source readable, bits 14:12, read-only
// - software writes new source code, bits 10:8
// - switch request bit 0; reads 0 when done
// - freeze bit 7 settable at mode 01, blocks switching
// - pll lock status readable on bit 5
// - clock fail flag set by monitor, software clears
// - pin select freeze refuses pin select writes
// - secondary oscillator enable bit 1, resets 0
// - registers reset only by power-on reset
// - recover on interrupt clears reduction enable
// - reduction field divides by 2^code, reset 011
// - reduction enable off forces ratio 1:1
// - fast rc postscaler field, reset 000
// - pll postscaler field, reset 01
// - pll prescaler field, value plus two
// - pll multiplier field, reset gives 50
// - six-bit signed fast rc tuning field
// - unimplemented bits read zero, writes ignored
// - source fields initialised from configuration bits
// - mode 1x disables switching and monitor
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
module occr_regs
	import occr_pkg::*;
#(
	parameter int ADR_W = 8
)
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic [2:0] source_selection_config_in,
	input wire logic [1:0] switching_mode_setting_in,
	input wire logic switch_done_in,
	input wire logic pll_locked_in,
	input wire logic clock_fail_detect_in,
	input wire logic interrupt_in,
	input wire logic pin_select_write_in,
	output logic pin_select_write_out,
	output logic [2:0] current_source_out,
	output logic [2:0] new_source_out,
	output logic switch_request_out,
	output logic switching_enable_out,
	output logic fail_safe_monitor_enable_out,
	output logic secondary_osc_enable_out,
	output logic [2:0] reduction_ratio_out,
	output logic [2:0] fast_rc_postscaler_out,
	output logic [1:0] pll_postscaler_out,
	output logic [4:0] pll_prescaler_out,
	output logic [8:0] pll_multiplier_out,
	output logic [5:0] tuning_value_out
);
	logic ack_r;
	logic [31:0] rdata_r;
	logic init_done_r;
	logic [2:0] current_source_r;
	logic [2:0] new_source_r;
	logic source_freeze_r;
	logic pin_select_freeze_r;
	logic pll_lock_r;
	logic clock_fail_flag_r;
	logic secondary_osc_enable_r;
	logic switch_request_r;
	logic recover_on_interrupt_r;
	logic [2:0] reduction_r;
	logic reduction_enable_r;
	logic [2:0] fast_rc_postscaler_r;
	logic [1:0] pll_postscaler_r;
	logic [4:0] pll_prescaler_r;
	logic [8:0] pll_multiplier_r;
	logic [5:0] tuning_value_r;
	logic [2:0] reduction_ratio_r;
	logic pin_select_write_r;
	logic switch_en_r;
	logic monitor_en_r;
	logic access;
	logic wr;
	logic wr_lo;
	logic wr_hi;
	logic hit_ctl;
	logic hit_div;
	logic hit_fbd;
	logic hit_tun;
	logic switch_allowed;
	logic [15:0] ctl_view;
	logic [15:0] div_view;
	logic [31:0] rdata_nxt;

	assign access = wb_cyc_in & wb_stb_in & ~ack_r;
	assign wr = access & wb_we_in;
	assign wr_lo = wr & wb_sel_in[0];
	assign wr_hi = wr & wb_sel_in[1];
	assign hit_ctl = (wb_adr_in == ADR_W'(OCCR_OFF_CONTROL));
	assign hit_div = (wb_adr_in == ADR_W'(OCCR_OFF_DIVISOR));
	assign hit_fbd = (wb_adr_in == ADR_W'(OCCR_OFF_FEEDBACK));
	assign hit_tun = (wb_adr_in == ADR_W'(OCCR_OFF_TUNING));
	// mode 1x or a frozen source stops any new switch
	assign switch_allowed = ~switching_mode_setting_in[1] & ~source_freeze_r;

	always_comb
	begin
		ctl_view = 16'h0000;
		ctl_view[OCCR_CUR_SRC_LSB +: 3] = current_source_r;
		ctl_view[OCCR_NEW_SRC_LSB +: 3] = new_source_r;
		ctl_view[OCCR_FREEZE_BIT] = source_freeze_r;
		ctl_view[OCCR_PIN_FREEZE_BIT] = pin_select_freeze_r;
		ctl_view[OCCR_LOCK_BIT] = pll_lock_r;
		ctl_view[OCCR_FAIL_BIT] = clock_fail_flag_r;
		ctl_view[OCCR_SEC_EN_BIT] = secondary_osc_enable_r;
		ctl_view[OCCR_SWITCH_BIT] = switch_request_r;
		div_view = 16'h0000;
		div_view[OCCR_ROI_BIT] = recover_on_interrupt_r;
		div_view[OCCR_REDUCTION_LSB +: 3] = reduction_r;
		div_view[OCCR_RED_EN_BIT] = reduction_enable_r;
		div_view[OCCR_FRC_POST_LSB +: 3] = fast_rc_postscaler_r;
		div_view[OCCR_PLL_POST_LSB +: 2] = pll_postscaler_r;
		div_view[OCCR_PLL_PRE_LSB +: 5] = pll_prescaler_r;
		rdata_nxt = 32'h0000_0000;
		if (hit_ctl)
			rdata_nxt = {16'h0000, ctl_view};
		else if (hit_div)
			rdata_nxt = {16'h0000, div_view};
		else if (hit_fbd)
			rdata_nxt = {23'h0, pll_multiplier_r};
		else if (hit_tun)
			rdata_nxt = {26'h0, tuning_value_r};
		else
			rdata_nxt = 32'h0000_0000;
	end

	// bus handshake: one wait state, ack for one cycle, unmapped reads zero
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= access;
			if (access && !wb_we_in)
				rdata_r <= rdata_nxt;
		end
	end

	// source fields; the only reset is power-on, other resets never reach here
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			init_done_r <= 1'b0;
			current_source_r <= OCCR_SRC_RST;
			new_source_r <= OCCR_SRC_RST;
			switch_request_r <= 1'b0;
		end
		else if (!init_done_r)
		begin
			init_done_r <= 1'b1;
			current_source_r <= source_selection_config_in;
			new_source_r <= source_selection_config_in;
		end
		else
		begin
			if (wr_hi && hit_ctl)
				new_source_r <= wb_dat_in[OCCR_NEW_SRC_LSB +: 3];
			if (switch_request_r && switch_done_in)
			begin
				current_source_r <= new_source_r;
				switch_request_r <= 1'b0;
			end
			else if (wr_lo && hit_ctl && wb_dat_in[OCCR_SWITCH_BIT] && switch_allowed)
				switch_request_r <= 1'b1;
		end
	end

	// control flags
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			source_freeze_r <= 1'b0;
			pin_select_freeze_r <= 1'b0;
			secondary_osc_enable_r <= 1'b0;
			clock_fail_flag_r <= 1'b0;
			pll_lock_r <= 1'b0;
		end
		else
		begin
			pll_lock_r <= pll_locked_in;
			if (wr_lo && hit_ctl)
			begin
				if (wb_dat_in[OCCR_FREEZE_BIT]
					&& switching_mode_setting_in == OCCR_MODE_NO_MONITOR)
					source_freeze_r <= 1'b1;
				pin_select_freeze_r <= wb_dat_in[OCCR_PIN_FREEZE_BIT];
				secondary_osc_enable_r <= wb_dat_in[OCCR_SEC_EN_BIT];
			end
			// a failure in the clearing cycle still sets the flag
			if (clock_fail_detect_in && switching_mode_setting_in == OCCR_MODE_ALL_ON)
				clock_fail_flag_r <= 1'b1;
			else if (wr_lo && hit_ctl && !wb_dat_in[OCCR_FAIL_BIT])
				clock_fail_flag_r <= 1'b0;
		end
	end

	// divisor register
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			recover_on_interrupt_r <= 1'b0;
			reduction_r <= OCCR_REDUCTION_RST;
			reduction_enable_r <= 1'b0;
			fast_rc_postscaler_r <= OCCR_FRC_POST_RST;
			pll_postscaler_r <= OCCR_PLL_POST_RST;
			pll_prescaler_r <= OCCR_PLL_PRE_RST;
		end
		else
		begin
			if (wr_hi && hit_div)
			begin
				recover_on_interrupt_r <= wb_dat_in[OCCR_ROI_BIT];
				reduction_r <= wb_dat_in[OCCR_REDUCTION_LSB +: 3];
				fast_rc_postscaler_r <= wb_dat_in[OCCR_FRC_POST_LSB +: 3];
			end
			// with recover on interrupt set, an interrupt wins over a write in the same cycle
			if (recover_on_interrupt_r && interrupt_in)
				reduction_enable_r <= 1'b0;
			else if (wr_hi && hit_div)
				reduction_enable_r <= wb_dat_in[OCCR_RED_EN_BIT];
			if (wr_lo && hit_div)
			begin
				pll_postscaler_r <= wb_dat_in[OCCR_PLL_POST_LSB +: 2];
				pll_prescaler_r <= wb_dat_in[OCCR_PLL_PRE_LSB +: 5];
			end
		end
	end

	// feedback multiplier and tuning
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pll_multiplier_r <= OCCR_MULT_RST;
			tuning_value_r <= OCCR_TUNE_RST;
		end
		else
		begin
			if (wr_lo && hit_fbd)
				pll_multiplier_r[7:0] <= wb_dat_in[OCCR_MULT_LSB +: 8];
			if (wr_hi && hit_fbd)
				pll_multiplier_r[8] <= wb_dat_in[OCCR_MULT_LSB + 8];
			if (wr_lo && hit_tun)
				tuning_value_r <= wb_dat_in[OCCR_TUNE_LSB +: 6];
		end
	end

	// derived outputs for the clock tree
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			reduction_ratio_r <= 3'h0;
			pin_select_write_r <= 1'b0;
			switch_en_r <= 1'b0;
			monitor_en_r <= 1'b0;
		end
		else
		begin
			reduction_ratio_r <= reduction_enable_r ? reduction_r : 3'h0;
			pin_select_write_r <= pin_select_write_in & ~pin_select_freeze_r;
			switch_en_r <= ~switching_mode_setting_in[1];
			monitor_en_r <= (switching_mode_setting_in == OCCR_MODE_ALL_ON);
		end
	end

	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdata_r;
	assign current_source_out = current_source_r;
	assign new_source_out = new_source_r;
	assign switch_request_out = switch_request_r;
	assign switching_enable_out = switch_en_r;
	assign fail_safe_monitor_enable_out = monitor_en_r;
	assign secondary_osc_enable_out = secondary_osc_enable_r;
	assign reduction_ratio_out = reduction_ratio_r;
	assign fast_rc_postscaler_out = fast_rc_postscaler_r;
	assign pll_postscaler_out = pll_postscaler_r;
	assign pll_prescaler_out = pll_prescaler_r;
	assign pll_multiplier_out = pll_multiplier_r;
	assign tuning_value_out = tuning_value_r;
	assign pin_select_write_out = pin_select_write_r;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_switch_completes: assert property (init_done_r && switch_request_r && switch_done_in
		|=> current_source_r == $past(new_source_r) && !switch_request_r)
		else $error("switch completion did not load current source");
	a_switch_blocked: assert property (init_done_r && !switch_request_r
		&& (source_freeze_r || switching_mode_setting_in[1]) |=> !switch_request_r)
		else $error("switch request set while switching blocked");
	a_freeze_sticky: assert property (source_freeze_r |=> source_freeze_r)
		else $error("source freeze cleared without reset");
	a_fail_sets: assert property (clock_fail_detect_in
		&& switching_mode_setting_in == OCCR_MODE_ALL_ON |=> clock_fail_flag_r)
		else $error("clock failure not flagged");
	a_fail_cause: assert property ($rose(clock_fail_flag_r) |-> $past(clock_fail_detect_in)
		&& $past(switching_mode_setting_in) == OCCR_MODE_ALL_ON)
		else $error("clock fail flag set without monitor event");
	a_recover_clears: assert property (recover_on_interrupt_r && interrupt_in
		|=> !reduction_enable_r ##1 reduction_ratio_r == 3'h0)
		else $error("interrupt did not restore 1:1 ratio");
	a_ratio_forced: assert property (!reduction_enable_r |=> reduction_ratio_r == 3'h0)
		else $error("ratio not 1:1 with reduction disabled");
	a_pin_refused: assert property (pin_select_freeze_r && pin_select_write_in
		|=> !pin_select_write_out)
		else $error("pin select write passed while frozen");
	a_lock_follows: assert property (pll_lock_r == $past(pll_locked_in))
		else $error("lock status does not follow pll");
	a_unused_zero: assert property (ack_r && $past(hit_tun && !wb_we_in)
		|-> wb_dat_out[31:6] == 26'h0)
		else $error("unimplemented tuning bits read nonzero");
	a_ack_single: assert property (ack_r |=> !ack_r)
		else $error("ack held longer than one cycle");

	c_switch_done: cover property (switch_request_r ##[1:20] !switch_request_r);
	c_fail_flag: cover property ($rose(clock_fail_flag_r));
	c_recover: cover property (reduction_enable_r ##1 !reduction_enable_r);
	c_pin_refused: cover property (pin_select_freeze_r && pin_select_write_in);
endmodule : occr_regs

//--- tb/tb_top.sv
// self-checking bench for the oscillator control register set
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top
	import occr_pkg::*;
;
	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [2:0] cfg = 3'h5;
	logic [1:0] mode = 2'h0;
	logic locked = 1'b0;
	logic [3:0] ev = 4'h0;
	logic pin_wr_out, sw_req, sw_en, mon_en, sec_en;
	logic [2:0] cur_src, new_src, ratio, frc_post;
	logic [1:0] pll_post;
	logic [4:0] pll_pre;
	logic [8:0] mult;
	logic [5:0] tune;
	int err_total = 0;
	int cmp_count = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	occr_regs dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .source_selection_config_in(cfg),
		.switching_mode_setting_in(mode), .switch_done_in(ev[0]), .pll_locked_in(locked),
		.clock_fail_detect_in(ev[1]), .interrupt_in(ev[2]), .pin_select_write_in(ev[3]),
		.pin_select_write_out(pin_wr_out), .current_source_out(cur_src),
		.new_source_out(new_src), .switch_request_out(sw_req), .switching_enable_out(sw_en),
		.fail_safe_monitor_enable_out(mon_en), .secondary_osc_enable_out(sec_en),
		.reduction_ratio_out(ratio), .fast_rc_postscaler_out(frc_post),
		.pll_postscaler_out(pll_post), .pll_prescaler_out(pll_pre), .pll_multiplier_out(mult),
		.tuning_value_out(tune));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
		begin
			$display("Simulation passed");
		end
		else
		begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	// one classic cycle, held until ack is sampled high
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {16'h0000, d};
		do
		begin
			@(posedge ref_clk_in);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
		begin
			err_total++;
			summarize();
		end
	endtask : wb_xfer
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
		logic [31:0] r;
		wb_xfer(1'b1, a, d, s, r);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb_xfer(1'b0, a, 16'h0000, 4'h3, r);
		`CHK(r, e);
	endtask : rd_chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : tick
	task automatic pulse(input int i);
		@(posedge ref_clk_in);
		ev[i] <= 1'b1;
		@(posedge ref_clk_in);
		ev[i] <= 1'b0;
		#1;
	endtask : pulse
	task automatic por(input logic [2:0] s);
		@(posedge ref_clk_in);
		cfg <= s;
		reset_n_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		tick(2);
	endtask : por
	task automatic chk_reset(input logic [2:0] s);
		rd_chk(OCCR_OFF_CONTROL, {17'h0, s, 1'b0, s, 8'h00});
		rd_chk(OCCR_OFF_DIVISOR, 32'h0000_3040);
		rd_chk(OCCR_OFF_FEEDBACK, 32'h0000_0030);
		rd_chk(OCCR_OFF_TUNING, 32'h0000_0000);
		rd_chk(8'h10, 32'h0000_0000);
		`CHK(cur_src, s);
		`CHK(ratio, 3'h0);
	endtask : chk_reset
	initial
	begin
		por(3'h5);
		chk_reset(3'h5);
		// divisor fields at their extremes, then interrupt recovery, then feedback, tuning and unmapped writes
		wr(OCCR_OFF_DIVISOR, 16'hFFFF);
		rd_chk(OCCR_OFF_DIVISOR, 32'h0000_FFDF);
		tick(2);
		`CHK({ratio, frc_post, pll_post, pll_pre}, 13'h1FFF);
		pulse(2);
		tick(1);
		`CHK(ratio, 3'h0);
		rd_chk(OCCR_OFF_DIVISOR, 32'h0000_F7DF);
		wr(OCCR_OFF_DIVISOR, 16'h3800);
		pulse(2);
		tick(1);
		`CHK(ratio, 3'h3);
		rd_chk(OCCR_OFF_DIVISOR, 32'h0000_3800);
		wr(OCCR_OFF_FEEDBACK, 16'hFFFF, 4'h1);
		rd_chk(OCCR_OFF_FEEDBACK, 32'h0000_00FF);
		wr(OCCR_OFF_FEEDBACK, 16'hFFFF);
		rd_chk(OCCR_OFF_FEEDBACK, 32'h0000_01FF);
		wr(OCCR_OFF_TUNING, 16'hFFFF);
		rd_chk(OCCR_OFF_TUNING, 32'h0000_003F);
		wr(OCCR_OFF_TUNING, 16'h0020);
		tick(1);
		`CHK({mult, tune}, 15'h7FE0);
		wr(8'h10, 16'hFFFF);
		rd_chk(8'h10, 32'h0000_0000);
		// clock switch request and completion
		wr(OCCR_OFF_CONTROL, 16'h0301);
		tick(1);
		`CHK({sw_req, new_src, cur_src}, 7'h5D);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_5301);
		pulse(0);
		`CHK({sw_req, cur_src}, 4'h3);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3300);
		// read-only bits ignored, pin select freeze, secondary enable
		wr(OCCR_OFF_CONTROL, 16'hF842);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3042);
		pulse(3);
		`CHK({pin_wr_out, sec_en}, 2'h1);
		wr(OCCR_OFF_CONTROL, 16'h0000);
		pulse(3);
		`CHK({pin_wr_out, sec_en}, 2'h2);
		// clock fail flag set by monitor, cleared only by software
		pulse(1);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3008);
		wr(OCCR_OFF_CONTROL, 16'h0008);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3008);
		wr(OCCR_OFF_CONTROL, 16'h0000);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3000);
		locked <= 1'b1;
		tick(2);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3020);
		// mode 1x: no switching, no monitor
		mode <= 2'h2;
		tick(2);
		`CHK({sw_en, mon_en}, 2'h0);
		wr(OCCR_OFF_CONTROL, 16'h0101);
		pulse(1);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_3120);
		// mode 01: switching without monitor, freeze honoured
		mode <= 2'h1;
		tick(2);
		`CHK({sw_en, mon_en}, 2'h2);
		wr(OCCR_OFF_CONTROL, 16'h0080);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_30A0);
		wr(OCCR_OFF_CONTROL, 16'h0281);
		tick(1);
		`CHK(sw_req, 1'b0);
		wr(OCCR_OFF_CONTROL, 16'h0000);
		rd_chk(OCCR_OFF_CONTROL, 32'h0000_30A0);
		mode <= 2'h0;
		locked <= 1'b0;
		tick(2);
		`CHK({sw_en, mon_en}, 2'h3);
		// second power-on reset with another configured source
		por(3'h6);
		chk_reset(3'h6);
		summarize();
	end
endmodule : tb_top
